// ---- inc/sbp_cfg.svh ----
// Offsets, field codes, reset values and timing constants of the base register bank
`ifndef SBP_CFG_SVH
`define SBP_CFG_SVH
`define SBP_NUM_REGS 16
`define SBP_PAGED_BASE 4'h8
`define SBP_ADDR_NODE 4'h0
`define SBP_ADDR_GAP 4'h1
`define SBP_ADDR_PORTS 4'h2
`define SBP_ADDR_SPEED 4'h3
`define SBP_ADDR_LINK 4'h4
`define SBP_ADDR_EVENT 4'h5
`define SBP_ADDR_RSVD6 4'h6
`define SBP_ADDR_PAGE 4'h7
`define SBP_GAP_RESET 6'h3f
`define SBP_EXT_CODE 3'h7
`define SBP_NUM_PORTS 4'h3
`define SBP_SPEED_CODE 3'h2
`define SBP_DELAY_CODE 4'h0
`define SBP_JITTER_CODE 3'h0
`define SBP_PAGE_RESET 3'h0
`define SBP_PORT_RESET 4'h0
`define SBP_LONG_RESET_NS 166000
`define SBP_SHORT_RESET_NS 1300
`define SBP_CLK_NS 10
`endif

// ---- inc/sbp_pkg.sv ----
// Types shared by the base register bank
package sbp_pkg;
    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } sbp_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sbp_apb_rsp_t;
    typedef struct packed {
        logic [5:0] node_address;
        logic root;
        logic self_id_done;
    } sbp_tree_t;
    typedef struct packed {
        logic link_bit;
        logic contender_bit;
        logic [2:0] power_class;
    } sbp_selfid_t;
    typedef enum logic [1:0] {
        SBP_IDLE,
        SBP_WAIT_IDLE,
        SBP_RESETTING
    } sbp_rst_state_t;
endpackage

// ---- verilog/sbp_base_regs.sv ----
// Base register bank of a three-port serial bus physical layer, reached over APB
//
// Operation
// RULE1: Sixteen registers; 0..7 fixed base, 8..15 a paged window.
// RULE2: Paged window shows one of eight pages chosen by base register seven. The code reads zero in the window for every page.
// RULE3: Base register fields mean the same whatever page is selected.
// RULE4: Reserved registers and fields read zero; pages two to six reserved.
// RULE5: Node address from self-identification; completion flagged by status transfer.
// RULE6: Root flag cleared by bus reset, set when tree identification makes root.
// RULE7: Cable power flag mirrors the cable power input; zero means low.
// RULE8: Root holdoff asks to become root; cleared by hardware reset only.
// RULE9: Long reset request starts long reset after traffic ends; cleared by resets.
// RULE10: Gap value set by register write or by configuration packet.
// RULE11: Gap value all ones at hardware reset or two resets without write.
// RULE12: Extended set code reads all ones.
// RULE13: Port total reads three.
// RULE14: Speed capability reads the 400 megabit code.
// RULE15: Repeater delay field reads zero.
// RULE16: Repeater jitter field reads zero.
// RULE17: Link active flag set by hardware reset, kept across bus resets.
// RULE18: Self-identification link bit is link active AND link power status.
// RULE19: Contender flag loads from contender pin at reset; copied to self-identification.
// RULE20: Contender pin is input only during hardware reset; driven otherwise. The code also releases it for the cycle after reset.
// RULE21: Power class loads from class pins at reset, kept, copied to self-identification.
// RULE22: Four interrupt flags cleared by hardware reset or by writing one.
// RULE23: Short reset request starts short arbitrated reset; cleared by bus reset.
// RULE24: Page selector picks page for addresses 8..15; reset clears it.
// RULE25: Registers eight bits wide, bit position zero is most significant.
`timescale 1ns/10ps
`default_nettype none
`include "sbp_cfg.svh"
module sbp_base_regs #(
    parameter int LONG_RESET_CYC = (`SBP_LONG_RESET_NS + `SBP_CLK_NS - 1) / `SBP_CLK_NS
) (
    input wire logic ref_clk_i,                     // Device clock, 100 MHz
    input wire logic sys_rst_i,                     // Synchronous hardware reset
    input wire sbp_pkg::sbp_apb_req_t apb_req_i,    // APB request
    output sbp_pkg::sbp_apb_rsp_t apb_rsp_o,        // APB answer
    input wire sbp_pkg::sbp_tree_t tree_i,          // Tree and self-id results
    input wire logic bus_reset_i,                   // Bus reset seen, one pulse
    input wire logic traffic_busy_i,                // Receive or transmit in progress
    input wire logic cfg_gap_valid_i,               // Configuration packet gap load
    input wire logic [5:0] cfg_gap_i,               // Gap from configuration packet
    input wire logic cable_power_i,                 // Cable power status pin
    input wire logic link_power_status_i,           // Link power status active pin
    input wire logic [2:0] power_class_pins_i,      // Power class pins
    input wire logic contender_linkon_pin_i,        // Contender/link-on pin, input side
    output logic contender_linkon_pin_o,            // Contender/link-on pin, drive value
    output logic contender_linkon_pin_oe_o,         // Contender/link-on pin enable
    input wire logic link_on_i,                     // Link-on request to signal on pin
    input wire logic cfg_timeout_i,                 // Config timeout event pulse
    input wire logic state_timeout_i,               // State timeout event pulse
    input wire logic port_event_i,                  // Port status change pulse
    input wire logic resume_start_i,                // Resume start on a port pulse
    output logic long_reset_o,                      // Long bus reset in progress
    output logic short_reset_req_o,                 // Short reset request to arbiter
    output logic status_xfer_o,                     // Unsolicited register zero transfer
    output logic [5:0] gap_count_o,                 // Arbitration gap value
    output logic root_holdoff_o,                    // Try to become root
    output logic arb_accel_enable_o,                // Arbitration acceleration enable
    output logic multispeed_concat_enable_o,        // Multispeed concatenation enable
    output logic [2:0] page_select_o,               // Selected page
    output logic [3:0] port_select_o,               // Selected port
    output sbp_pkg::sbp_selfid_t selfid_o,          // Self-id packet fields
    output logic [3:0] irq_flags_o                  // cfg, cable, state, port flags
);
    import sbp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, change taken once stages two and three agree

    logic [2:0] cps_sync_q;
    logic cps_q;
    logic cps_prev_q;
    logic [2:0] lps_sync_q;
    logic lps_q;

    always_ff @(posedge ref_clk_i) begin
        cps_sync_q <= {cps_sync_q[1:0], cable_power_i};
        lps_sync_q <= {lps_sync_q[1:0], link_power_status_i};
    end

    // Filtered levels; cable power resets to powered so no false drop event
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cps_q <= 1'b1;
            cps_prev_q <= 1'b1;
            lps_q <= 1'b0;
        end else begin
            if (cps_sync_q[1] == cps_sync_q[2]) begin
                cps_q <= cps_sync_q[2];
            end
            if (lps_sync_q[1] == lps_sync_q[2]) begin
                lps_q <= lps_sync_q[2];
            end
            cps_prev_q <= cps_q;
        end
    end

    // Straps: three stages, settled level latched
    logic [3:0] strap_a_q;
    logic [3:0] strap_b_q;
    logic [3:0] strap_c_q;
    logic [3:0] strap_q;

    always_ff @(posedge ref_clk_i) begin
        strap_a_q <= {contender_linkon_pin_i, power_class_pins_i};
        strap_b_q <= strap_a_q;
        strap_c_q <= strap_b_q;
        if (strap_b_q == strap_c_q) begin
            strap_q <= strap_c_q;
        end
    end

    wire cps_fall = cps_prev_q & ~cps_q;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; every access answers at once, out-of-range addresses get pslverr

    wire apb_setup = apb_req_i.psel & ~apb_req_i.penable;
    wire apb_wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
    wire apb_rd_setup = apb_setup & ~apb_req_i.pwrite;
    wire [3:0] reg_idx = apb_req_i.paddr[5:2];
    wire in_range = (apb_req_i.paddr[31:6] == 26'h0) & (apb_req_i.paddr[1:0] == 2'h0);
    wire [7:0] wdat = apb_req_i.pwdata[7:0];

    // All operands passed in
    function automatic logic wr_hit(input logic en, input logic [3:0] idx, input logic [3:0] want);
        wr_hit = en & (idx == want);
    endfunction

    wire wr_en = apb_wr & in_range;
    wire wr_gap = wr_hit(wr_en, reg_idx, `SBP_ADDR_GAP);
    wire wr_link = wr_hit(wr_en, reg_idx, `SBP_ADDR_LINK);
    wire wr_event = wr_hit(wr_en, reg_idx, `SBP_ADDR_EVENT);
    wire wr_page = wr_hit(wr_en, reg_idx, `SBP_ADDR_PAGE);

    ////////////////////////////////////////////////////////////////////////////
    // Control and status state

    logic root_holdoff_q;
    logic long_req_q;
    logic short_req_q;
    logic [5:0] gap_q;
    logic gap_written_q;
    logic link_active_q;
    logic contender_q;
    logic [2:0] power_class_q;
    logic resume_irq_enable_q;
    logic arb_accel_enable_q;
    logic multispeed_concat_enable_q;
    logic cfg_timeout_irq_q;
    logic cable_power_irq_q;
    logic state_timeout_irq_q;
    logic port_event_irq_q;
    logic [2:0] page_q;
    logic [3:0] port_q;
    logic root_q;
    logic rst_held_q;
    logic long_go;
    logic [31:0] prdata_q;

    // Root holdoff kept over bus resets
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            root_holdoff_q <= 1'b0; // [RULE8]
        end else if (wr_gap) begin
            root_holdoff_q <= wdat[7];
        end
    end

    // Reset requests: bus reset clears both, long reset start clears the long one; a write wins
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            long_req_q <= 1'b0;
            short_req_q <= 1'b0;
        end else begin
            if (wr_gap && wdat[6]) begin
                long_req_q <= 1'b1;
            end else if (bus_reset_i || long_go) begin
                long_req_q <= 1'b0; // [RULE9]
            end
            if (wr_event && wdat[6]) begin
                short_req_q <= 1'b1;
            end else if (bus_reset_i) begin
                short_req_q <= 1'b0; // [RULE23]
            end
        end
    end

    // Gap count; a second bus reset with no write between restores all ones
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            gap_q <= `SBP_GAP_RESET; // [RULE11]
            gap_written_q <= 1'b0;
        end else if (wr_gap) begin
            gap_q <= wdat[5:0]; // [RULE10]
            gap_written_q <= 1'b1;
        end else if (cfg_gap_valid_i) begin
            gap_q <= cfg_gap_i; // [RULE10]
            gap_written_q <= 1'b1;
        end else if (bus_reset_i) begin
            if (!gap_written_q) begin
                gap_q <= `SBP_GAP_RESET; // [RULE11]
            end
            gap_written_q <= 1'b0;
        end
    end

    // Straps latched while reset is held
    always_ff @(posedge ref_clk_i) begin
        rst_held_q <= sys_rst_i;
        if (sys_rst_i) begin
            link_active_q <= 1'b1; // [RULE17]
            contender_q <= strap_q[3]; // [RULE19]
            power_class_q <= strap_q[2:0]; // [RULE21]
        end else if (wr_link) begin
            link_active_q <= wdat[7];
            contender_q <= wdat[6];
            power_class_q <= wdat[2:0];
        end
    end

    // Feature enables and page/port selectors
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            resume_irq_enable_q <= 1'b0;
            arb_accel_enable_q <= 1'b0;
            multispeed_concat_enable_q <= 1'b0;
            page_q <= `SBP_PAGE_RESET; // [RULE24]
            port_q <= `SBP_PORT_RESET;
        end else begin
            if (wr_event) begin
                resume_irq_enable_q <= wdat[7];
                arb_accel_enable_q <= wdat[1];
                multispeed_concat_enable_q <= wdat[0];
            end
            if (wr_page) begin
                page_q <= wdat[7:5]; // [RULE24]
                port_q <= wdat[3:0];
            end
        end
    end

    // Sticky flags: an event in the clearing cycle wins over the clear
    wire ev_port = port_event_i | (resume_start_i & resume_irq_enable_q);
    wire [3:0] ev_set = {cfg_timeout_i, cps_fall, state_timeout_i, ev_port};
    wire [3:0] ev_clr = wr_event ? wdat[5:2] : 4'h0;
    wire [3:0] flags_q = {cfg_timeout_irq_q, cable_power_irq_q, state_timeout_irq_q, port_event_irq_q};
    wire [3:0] flags_d = ev_set | (flags_q & ~ev_clr);

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            {cfg_timeout_irq_q, cable_power_irq_q, state_timeout_irq_q, port_event_irq_q} <= 4'h0; // [RULE22]
        end else begin
            {cfg_timeout_irq_q, cable_power_irq_q, state_timeout_irq_q, port_event_irq_q} <= flags_d; // [RULE22]
        end
    end

    // Root flag: cleared on every bus reset
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || bus_reset_i) begin
            root_q <= 1'b0; // [RULE6]
        end else if (tree_i.root) begin
            root_q <= 1'b1; // [RULE6]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Long bus reset sequencer; waits for traffic to finish first

    sbp_rst_state_t rst_st_q;
    logic [31:0] rst_cnt_q;

    // Start of long reset retires request
    assign long_go = (rst_st_q == SBP_WAIT_IDLE) & ~traffic_busy_i; // [RULE9]

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rst_st_q <= SBP_IDLE;
            rst_cnt_q <= 32'h0;
        end else begin
            case (rst_st_q)
                SBP_IDLE: begin
                    if (long_req_q) begin
                        rst_st_q <= SBP_WAIT_IDLE;
                    end
                end
                SBP_WAIT_IDLE: begin
                    if (!traffic_busy_i) begin
                        rst_st_q <= SBP_RESETTING; // [RULE9]
                        rst_cnt_q <= 32'h0;
                    end
                end
                SBP_RESETTING: begin
                    if (rst_cnt_q >= 32'(LONG_RESET_CYC - 1)) begin
                        rst_st_q <= SBP_IDLE;
                    end else begin
                        rst_cnt_q <= rst_cnt_q + 32'h1;
                    end
                end
                default: begin
                    rst_st_q <= SBP_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; bit position zero of each register is its most significant bit

    logic [7:0] base_rd;
    wire [7:0] node_byte = {tree_i.node_address, root_q, cps_q}; // [RULE5] [RULE6] [RULE7]
    wire [7:0] ports_byte = {`SBP_EXT_CODE, 1'b0, `SBP_NUM_PORTS}; // [RULE12] [RULE13]
    wire [7:0] speed_byte = {`SBP_SPEED_CODE, 1'b0, `SBP_DELAY_CODE}; // [RULE14] [RULE15]
    wire [7:0] link_byte = {link_active_q, contender_q, `SBP_JITTER_CODE, power_class_q}; // [RULE16] [RULE25]
    wire [7:0] event_byte = {resume_irq_enable_q, short_req_q, flags_q, arb_accel_enable_q,
                             multispeed_concat_enable_q};

    // Base fields never depend on page_q
    always_comb begin
        case (reg_idx[2:0]) // [RULE3]
            3'h0: base_rd = node_byte;
            3'h1: base_rd = {root_holdoff_q, long_req_q, gap_q};
            3'h2: base_rd = ports_byte;
            3'h3: base_rd = speed_byte;
            3'h4: base_rd = link_byte;
            3'h5: base_rd = event_byte;
            3'h7: base_rd = {page_q, 1'b0, port_q};
            default: base_rd = 8'h00; // [RULE4]
        endcase
    end

    // Port pages belong to the port logic; the window reads zero
    wire [7:0] paged_rd = 8'h00; // [RULE2] [RULE4]
    wire [7:0] rd_byte = (reg_idx >= `SBP_PAGED_BASE) ? paged_rd : base_rd; // [RULE1]

    // Read data captured in setup, held through the access phase
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            prdata_q <= 32'h0;
        end else if (apb_rd_setup) begin
            prdata_q <= in_range ? {24'h0, rd_byte} : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        apb_rsp_o.prdata = prdata_q;
        apb_rsp_o.pready = 1'b1;
        apb_rsp_o.pslverr = apb_req_i.psel & apb_req_i.penable & ~in_range;
    end

    // Pin released during reset and the cycle after, then driven
    assign contender_linkon_pin_oe_o = ~sys_rst_i & ~rst_held_q; // [RULE20]
    assign contender_linkon_pin_o = link_on_i;
    assign long_reset_o = (rst_st_q == SBP_RESETTING);
    assign short_reset_req_o = short_req_q; // [RULE23]
    assign status_xfer_o = tree_i.self_id_done; // [RULE5]
    assign gap_count_o = gap_q;
    assign root_holdoff_o = root_holdoff_q; // [RULE8]
    assign arb_accel_enable_o = arb_accel_enable_q;
    assign multispeed_concat_enable_o = multispeed_concat_enable_q;
    assign page_select_o = page_q; // [RULE2]
    assign port_select_o = port_q;
    assign selfid_o.link_bit = link_active_q & lps_q; // [RULE18]
    assign selfid_o.contender_bit = contender_q; // [RULE19]
    assign selfid_o.power_class = power_class_q; // [RULE21]
    assign irq_flags_o = flags_q;
endmodule
`default_nettype wire

// ---- sim/sbp_base_regs_asserts.sv ----
// Port checker for the base register bank
`timescale 1ns/10ps
`default_nettype none
module sbp_base_regs_chk import sbp_pkg::*; #(
    parameter int LONG_RESET_CYC = 16600
) (
    input wire logic ref_clk_i,                  // Device clock
    input wire logic sys_rst_i,                  // Hardware reset
    input wire sbp_pkg::sbp_apb_req_t apb_req_i, // APB request
    input wire sbp_pkg::sbp_apb_rsp_t apb_rsp_o, // APB answer
    input wire logic traffic_busy_i,             // Traffic in progress
    input wire logic link_on_i,                  // Link-on request
    input wire logic port_event_i,               // Port event pulse
    input wire logic contender_linkon_pin_o,     // Pin drive value
    input wire logic contender_linkon_pin_oe_o,  // Pin enable
    input wire logic long_reset_o,               // Long reset running
    input wire logic [5:0] gap_count_o,          // Gap value
    input wire logic [3:0] irq_flags_o           // Event flags
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////
    // Access phase
    wire logic acc = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready;
    logic [15:0] run_q;
    // Cycles of the running long reset
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || !long_reset_o) run_q <= 16'h0;
        else run_q <= run_q + 16'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    a_ready_always: assert property (apb_rsp_o.pready) else $error("pready low");
    a_ports_fixed: assert property (acc && !apb_req_i.pwrite && apb_req_i.paddr == 32'h8
        |-> apb_rsp_o.prdata == 32'he3) else $error("port total field wrong");
    a_speed_fixed: assert property (acc && !apb_req_i.pwrite && apb_req_i.paddr == 32'hc
        |-> apb_rsp_o.prdata == 32'h40) else $error("speed field wrong");
    a_reserved_zero: assert property (acc && !apb_req_i.pwrite && (apb_req_i.paddr == 32'h18
        || apb_req_i.paddr inside {[32'h20:32'h3c]}) |-> apb_rsp_o.prdata == 32'h0) else $error("reserved not zero");
    a_bad_address: assert property (acc && (apb_req_i.paddr > 32'h3c || apb_req_i.paddr[1:0] != 2'h0)
        |-> apb_rsp_o.pslverr && (apb_req_i.pwrite || apb_rsp_o.prdata == 32'h0))
        else $error("unmapped access answered");
    a_gap_write: assert property (acc && apb_req_i.pwrite && apb_req_i.paddr == 32'h4
        |=> gap_count_o == $past(apb_req_i.pwdata[5:0])) else $error("gap write lost");
    a_long_length: assert property ($fell(long_reset_o) |-> run_q == LONG_RESET_CYC)
        else $error("long reset length wrong");
    a_long_idle: assert property ($rose(long_reset_o) |-> !$past(traffic_busy_i))
        else $error("long reset during traffic");
    a_pin_follows: assert property (contender_linkon_pin_oe_o |-> contender_linkon_pin_o == link_on_i)
        else $error("pin value wrong");
    a_pin_driven: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2) |-> contender_linkon_pin_oe_o)
        else $error("pin not driven");
    a_flag_clear: assert property (acc && apb_req_i.pwrite && apb_req_i.paddr == 32'h14
        && apb_req_i.pwdata[2] && !port_event_i |=> !irq_flags_o[0]) else $error("flag not cleared");
endmodule
bind sbp_base_regs sbp_base_regs_chk #(.LONG_RESET_CYC(LONG_RESET_CYC)) u_chk (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .traffic_busy_i(traffic_busy_i),
    .link_on_i(link_on_i), .port_event_i(port_event_i), .contender_linkon_pin_o(contender_linkon_pin_o),
    .contender_linkon_pin_oe_o(contender_linkon_pin_oe_o), .long_reset_o(long_reset_o),
    .gap_count_o(gap_count_o), .irq_flags_o(irq_flags_o));
`default_nettype wire

// ---- sim/sbp_link_model.sv ----
// Link-layer controller model: APB master toward the register bank
`timescale 1ns/10ps
`default_nettype none
module sbp_link_model import sbp_pkg::*; (
    input wire logic ref_clk_i,                   // Device clock
    input wire sbp_pkg::sbp_apb_rsp_t apb_rsp_i,  // Answer from bank
    output var sbp_pkg::sbp_apb_req_t apb_req_o   // Request to bank
);
    initial apb_req_o = '0;
    ////////////////////////////////////////////////////////////////////////
    // One transfer, held until pready is seen
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        @(posedge ref_clk_i);
        apb_req_o.paddr <= addr;
        apb_req_o.pwrite <= wr;
        apb_req_o.pwdata <= wdata;
        apb_req_o.psel <= 1'b1;
        apb_req_o.penable <= 1'b0;
        @(posedge ref_clk_i);
        apb_req_o.penable <= 1'b1;
        @(posedge ref_clk_i);
        while (apb_rsp_i.pready !== 1'b1) @(posedge ref_clk_i);
        apb_req_o.psel <= 1'b0;
        apb_req_o.penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the base register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sbp_pkg::*;
    logic ref_clk_i, sys_rst_i, busy, cable, lkon, cpin, pin_o, pin_oe, long_rst, short_req, link_power_status;
    logic [5:0] ev, gap, g;
    logic [2:0] pc;
    logic [3:0] irq;
    logic [31:0] rnd;
    logic [7:0] dflt [8];
    logic [32:0] expq [$];
    int err_count = 0, checks = 0, cyc = 0, n;
    sbp_apb_req_t req;
    sbp_apb_rsp_t rsp;
    sbp_tree_t tree;
    sbp_selfid_t sid;
    // Pin level: own drive when enabled, else strap
    wire logic pin_w = pin_oe ? pin_o : cpin;
    sbp_link_model LNK (.ref_clk_i(ref_clk_i), .apb_rsp_i(rsp), .apb_req_o(req));
    sbp_base_regs #(.LONG_RESET_CYC(20)) DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .apb_req_i(req),
        .apb_rsp_o(rsp), .tree_i(tree), .bus_reset_i(ev[0]), .traffic_busy_i(busy), .cfg_gap_valid_i(ev[5]),
        .cfg_gap_i(gap), .cable_power_i(cable), .link_power_status_i(link_power_status), .power_class_pins_i(pc),
        .contender_linkon_pin_i(pin_w), .contender_linkon_pin_o(pin_o), .contender_linkon_pin_oe_o(pin_oe),
        .link_on_i(lkon), .cfg_timeout_i(ev[1]), .state_timeout_i(ev[2]), .port_event_i(ev[3]),
        .resume_start_i(ev[4]), .long_reset_o(long_rst), .short_reset_req_o(short_req), .status_xfer_o(),
        .gap_count_o(), .root_holdoff_o(), .arb_accel_enable_o(), .multispeed_concat_enable_o(),
        .page_select_o(), .port_select_o(), .selfid_o(sid), .irq_flags_o(irq));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [32:0] e, input logic [32:0] v);
        checks++;
        if (v !== e) begin
            err_count++;
            $display("mismatch at %0t exp %h got %h", $time, e, v);
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic er = 1'b0);
        expq.push_back({er, 24'h0, e});
        rnd = lfsr(rnd);
        LNK.xfer(1'b0, a, rnd);
    endtask
    // Upper data bits random: the bank must ignore them
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        rnd = lfsr(rnd);
        LNK.xfer(1'b1, a, {rnd[31:8], d});
    endtask
    task automatic pulse(input int i);
        @(posedge ref_clk_i);
        ev <= 6'h1 << i;
        @(posedge ref_clk_i);
        ev <= 6'h0;
    endtask
    task automatic results();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reads compared at the edge that ends the access
    always @(posedge ref_clk_i) begin
        cyc++;
        if (req.psel && req.penable && rsp.pready && !req.pwrite) begin
            if (expq.size() == 0) chk(33'h0, 33'h1ffffffff);
            else chk(expq.pop_front(), {rsp.pslverr, rsp.prdata});
        end
        if (cyc == 4000) begin
            err_count++;
            results();
        end
    end
    initial begin
        sys_rst_i = 1'b1; ev = 6'h0; busy = 1'b0; cable = 1'b1; lkon = 1'b1; cpin = 1'b1; pc = 3'h5;
        gap = 6'h2a; tree = '0; link_power_status = 1'b1;
        rnd = lfsr(32'hf8e364e2);
        tree.node_address = rnd[5:0];
        dflt = '{{rnd[5:0], 2'b01}, 8'h3f, 8'he3, 8'h40, 8'hc5, 8'h00, 8'h00, 8'h00};
        repeat (20) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        cpin <= 1'b0;
        repeat (2) @(negedge ref_clk_i);
        chk({28'h0, sid}, {28'h0, 5'b11101});
        for (int i = 0; i < 8; i++) rd(4 * i, dflt[i]);
        wr(32'h8, 8'h00);
        rd(32'h8, 8'he3);
        wr(32'hc, 8'hff);
        rd(32'hc, 8'h40);
        // Page window: every page reads zero, register two unchanged
        foreach (dflt[p]) begin
            wr(32'h1c, {p[2:0], 5'h1f});
            rd(32'h1c, {p[2:0], 5'h0f});
            for (int i = 8; i < 16; i++) rd(4 * i, 8'h00);
            rd(32'h8, 8'he3);
        end
        wr(32'h44, 8'hff);
        rd(32'h44, 8'h00, 1'b1);
        rd(32'h2, 8'h00, 1'b1);
        // Gap kept over one bus reset, all ones after two
        rnd = lfsr(rnd);
        g = {1'b0, rnd[4:0]};
        wr(32'h4, {2'b10, g});
        rd(32'h4, {2'b10, g});
        pulse(0);
        rd(32'h4, {2'b10, g});
        pulse(0);
        rd(32'h4, 8'hbf);
        pulse(5);
        rd(32'h4, 8'haa);
        // Long reset waits for traffic to finish
        busy <= 1'b1;
        wr(32'h4, 8'hff);
        rd(32'h4, 8'hff);
        repeat (10) @(posedge ref_clk_i);
        chk({32'h0, long_rst}, 33'h0);
        busy <= 1'b0;
        n = 0;
        while (long_rst !== 1'b1 && n < 50) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk({32'h0, long_rst}, 33'h1);
        while (long_rst === 1'b1 && n < 100) begin
            @(posedge ref_clk_i);
            n++;
        end
        pulse(0);
        rd(32'h4, 8'hbf);
        // Event flags set, read, cleared by writing ones
        wr(32'h14, 8'h80);
        pulse(1);
        pulse(2);
        pulse(4);
        cable <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        rd(32'h0, {tree.node_address, 2'b00});
        cable <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        rd(32'h14, 8'hbc);
        pulse(3);
        wr(32'h14, 8'h3c);
        rd(32'h14, 8'h00);
        wr(32'h14, 8'h43);
        rd(32'h14, 8'h43);
        chk({32'h0, short_req}, 33'h1);
        pulse(0);
        rd(32'h14, 8'h03);
        // Root flag set by tree identification, cleared by bus reset
        @(posedge ref_clk_i);
        tree.root <= 1'b1;
        tree.self_id_done <= 1'b1;
        @(posedge ref_clk_i);
        tree <= '{node_address: tree.node_address, root: 1'b0, self_id_done: 1'b0};
        rd(32'h0, {tree.node_address, 2'b11});
        pulse(0);
        rd(32'h0, {tree.node_address, 2'b01});
        wr(32'h10, 8'h82);
        rd(32'h10, 8'h82);
        chk({28'h0, sid}, {28'h0, 5'b10010});
        link_power_status <= 1'b0;
        repeat (6) @(negedge ref_clk_i);
        chk({28'h0, sid}, {28'h0, 5'b00010});
        results();
    end
endmodule
`default_nettype wire
